//--- design/analog_comparator_control.sv
/*
 * Digital control around an on-chip voltage comparator: synchroniser, edge
 * event detection, interrupt flag, input selection, power and capture route.
 * Assumes the analog core reports its raw decision on cmp_raw, that the
 * selection outputs steer analog switches, and that all inputs are
 * synchronous to pclk except cmp_raw, which is synchronised here.
 */
// The implementer's own choices: the APB interface to the registers and the address map.
// Functional notes
// - Raw result high when positive exceeds negative
// - Result synchronised, one to two cycle latency; the result bit here lags cmp_raw by two to three
// - Selected event sets interrupt flag
// - Mode 00 toggle, 01 reserved, 10 fall, 11 rise
// - Request needs flag, enable and global enable
// - Flag cleared by vector or written one
// - Disable bit powers comparator off anytime
// - Bandgap select picks positive input source
// - Capture route feeds result to timer
// - Mux enable, converter off picks channel input
// - Converter control B layout, reset zero
// - Pin input disable forces port bit zero
// - Converter on only while its enable set
module analog_comparator_control
   import cmp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        cmp_raw,
   input  wire logic        vector_ack,
   input  wire logic        pos_pin_digital,
   input  wire logic        neg_pin_digital,
   output logic             cmp_power_off,
   output logic             pos_use_bandgap,
   output logic             neg_use_channel,
   output logic [2:0]       neg_channel_select,
   output logic             capture_input,
   output logic             pos_port_bit,
   output logic             neg_port_bit,
   output logic             cmp_irq_req,
   output logic             irq
);

   logic [7:0]  ctrl;
   logic [7:0]  conv_b;
   logic [7:0]  pin_off;
   logic [7:0]  conv_a;
   logic [7:0]  conv_ch;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic        global_ie;
   logic        sync_a;
   logic        sync_b;
   logic        sync_prev;

   logic [7:0]  next_ctrl;
   logic [7:0]  next_conv_b;
   logic [7:0]  next_pin_off;
   logic [7:0]  next_conv_a;
   logic [7:0]  next_conv_ch;
   logic [1:0]  next_irq_status;
   logic [1:0]  next_irq_mask;
   logic        next_global_ie;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        next_power_off;
   logic        next_bandgap;
   logic        next_use_channel;
   logic [2:0]  next_channel;
   logic        next_capture;
   logic        next_pos_port;
   logic        next_neg_port;
   logic        next_irq_req;
   logic        next_irq;

   logic        wr;
   logic        rd;
   logic        event_hit;
   logic        capture_edge;

   function automatic logic addr_known(input logic [7:0] a);
      case (a)
         OFF_CONV_CTRL_B, OFF_CMP_CTRL, OFF_PIN_DISABLE, OFF_CONV_CTRL_A,
         OFF_CONV_CHANNEL, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_GLOBAL_IRQ: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   endfunction

   function automatic logic mode_event(input logic [1:0] mode, input logic cur, input logic prev);
      case (irq_mode_t'(mode))
         MODE_TOGGLE:  mode_event = cur ^ prev;
         MODE_FALLING: mode_event = prev & ~cur;
         MODE_RISING:  mode_event = cur & ~prev;
         default:      mode_event = 1'b0;
      endcase
   endfunction

   // Access phase of a transfer; the slave answers after one wait state
   assign wr = psel & penable & pwrite & ~pready;
   assign rd = psel & penable & ~pwrite & ~pready;

   // Event on the synchronised result versus its previous sample
   assign event_hit = mode_event({ctrl[BIT_MODE_HI], ctrl[BIT_MODE_LO]}, sync_b, sync_prev);
   assign capture_edge = ctrl[BIT_CAPTURE] & (sync_b ^ sync_prev);

   always_comb begin
      next_ctrl       = ctrl;
      next_conv_b     = conv_b;
      next_pin_off    = pin_off;
      next_conv_a     = conv_a;
      next_conv_ch    = conv_ch;
      next_irq_status = irq_status;
      next_irq_mask   = irq_mask;
      next_global_ie  = global_ie;
      next_pready     = psel & penable & ~pready;
      next_pslverr    = psel & penable & ~pready & ~addr_known(paddr);
      next_prdata     = 32'h0000_0000;

      // Interrupt vector and write-one clear, then a new event wins
      if (vector_ack) begin
         next_ctrl[BIT_IRQ_FLAG] = 1'b0;
      end
      if (wr) begin
         case (paddr)
            OFF_CMP_CTRL: begin
               next_ctrl[7:6] = pwdata[7:6];
               next_ctrl[3:0] = pwdata[3:0];
               if (pwdata[BIT_IRQ_FLAG]) begin
                  next_ctrl[BIT_IRQ_FLAG] = 1'b0;
               end
            end
            OFF_CONV_CTRL_B: begin
               next_conv_b = {1'b0, pwdata[BIT_MUX_ENABLE], 3'b000, pwdata[BIT_TRIG_HI:0]};
            end
            OFF_PIN_DISABLE:  next_pin_off = {6'b00_0000, pwdata[1:0]};
            OFF_CONV_CTRL_A:  next_conv_a = pwdata[7:0];
            OFF_CONV_CHANNEL: next_conv_ch = pwdata[7:0];
            OFF_IRQ_STATUS:   next_irq_status = irq_status & ~pwdata[1:0];
            OFF_IRQ_MASK:     next_irq_mask = pwdata[1:0];
            OFF_GLOBAL_IRQ:   next_global_ie = pwdata[0];
            default: begin
            end
         endcase
      end
      if (event_hit) begin
         next_ctrl[BIT_IRQ_FLAG] = 1'b1;
         next_irq_status[BIT_ST_EVENT] = 1'b1;
      end
      if (capture_edge) begin
         next_irq_status[BIT_ST_CAPTURE] = 1'b1;
      end
      next_ctrl[BIT_RESULT] = sync_b;

      if (rd) begin
         case (paddr)
            OFF_CMP_CTRL:     next_prdata = {24'h00_0000, ctrl};
            OFF_CONV_CTRL_B:  next_prdata = {24'h00_0000, conv_b};
            OFF_PIN_DISABLE:  next_prdata = {24'h00_0000, pin_off};
            OFF_CONV_CTRL_A:  next_prdata = {24'h00_0000, conv_a};
            OFF_CONV_CHANNEL: next_prdata = {24'h00_0000, conv_ch};
            OFF_IRQ_STATUS:   next_prdata = {30'h0000_0000, irq_status};
            OFF_IRQ_MASK:     next_prdata = {30'h0000_0000, irq_mask};
            OFF_GLOBAL_IRQ:   next_prdata = {31'h0000_0000, global_ie};
            default:          next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // Outputs to the analog core, timer, ports and interrupt requests
   always_comb begin
      next_power_off   = ctrl[BIT_POWER_OFF];
      next_bandgap     = ctrl[BIT_BANDGAP];
      next_use_channel = conv_b[BIT_MUX_ENABLE] & ~conv_a[BIT_CONV_ENABLE];
      next_channel     = conv_ch[2:0];
      next_capture     = ctrl[BIT_CAPTURE] & sync_b;
      next_pos_port    = pos_pin_digital & ~pin_off[BIT_POS_OFF];
      next_neg_port    = neg_pin_digital & ~pin_off[BIT_NEG_OFF];
      next_irq_req     = ctrl[BIT_IRQ_FLAG] & ctrl[BIT_IRQ_ENABLE] & global_ie;
      next_irq         = |(irq_status & irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl       <= RST_CMP_CTRL;
         conv_b     <= RST_BYTE;
         pin_off    <= RST_BYTE;
         conv_a     <= RST_BYTE;
         conv_ch    <= RST_BYTE;
         irq_status <= 2'b00;
         irq_mask   <= 2'b00;
         global_ie  <= 1'b0;
         sync_a     <= 1'b0;
         sync_b     <= 1'b0;
         sync_prev  <= 1'b0;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h0000_0000;
      end else begin
         ctrl       <= next_ctrl;
         conv_b     <= next_conv_b;
         pin_off    <= next_pin_off;
         conv_a     <= next_conv_a;
         conv_ch    <= next_conv_ch;
         irq_status <= next_irq_status;
         irq_mask   <= next_irq_mask;
         global_ie  <= next_global_ie;
         sync_a     <= cmp_raw;
         sync_b     <= sync_a;
         sync_prev  <= sync_b;
         pready     <= next_pready;
         pslverr    <= next_pslverr;
         prdata     <= next_prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_power_off      <= 1'b0;
         pos_use_bandgap    <= 1'b0;
         neg_use_channel    <= 1'b0;
         neg_channel_select <= 3'b000;
         capture_input      <= 1'b0;
         pos_port_bit       <= 1'b0;
         neg_port_bit       <= 1'b0;
         cmp_irq_req        <= 1'b0;
         irq                <= 1'b0;
      end else begin
         cmp_power_off      <= next_power_off;
         pos_use_bandgap    <= next_bandgap;
         neg_use_channel    <= next_use_channel;
         neg_channel_select <= next_channel;
         capture_input      <= next_capture;
         pos_port_bit       <= next_pos_port;
         neg_port_bit       <= next_neg_port;
         cmp_irq_req        <= next_irq_req;
         irq                <= next_irq;
      end
   end

endmodule

//--- design/cmp_pkg.sv
/*
 * Package for the comparator control block: register offsets, bit positions,
 * reset values and interrupt mode encodings.
 * Assumes a 32-bit APB with each register on its own aligned word.
 */
package cmp_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CONV_CTRL_B   = 8'h00;
   localparam logic [7:0] OFF_CMP_CTRL      = 8'h04;
   localparam logic [7:0] OFF_PIN_DISABLE   = 8'h08;
   localparam logic [7:0] OFF_CONV_CTRL_A   = 8'h0C;
   localparam logic [7:0] OFF_CONV_CHANNEL  = 8'h10;
   localparam logic [7:0] OFF_IRQ_STATUS    = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK      = 8'h18;
   localparam logic [7:0] OFF_GLOBAL_IRQ    = 8'h1C;

   // comparator_control_status bits
   localparam int BIT_POWER_OFF   = 7;
   localparam int BIT_BANDGAP     = 6;
   localparam int BIT_RESULT      = 5;
   localparam int BIT_IRQ_FLAG    = 4;
   localparam int BIT_IRQ_ENABLE  = 3;
   localparam int BIT_CAPTURE     = 2;
   localparam int BIT_MODE_HI     = 1;
   localparam int BIT_MODE_LO     = 0;

   // converter_control_b bits
   localparam int BIT_MUX_ENABLE  = 6;
   localparam int BIT_TRIG_HI     = 2;

   // comparator_pin_input_disable bits
   localparam int BIT_NEG_OFF     = 1;
   localparam int BIT_POS_OFF     = 0;

   // converter_control_a enable bit
   localparam int BIT_CONV_ENABLE = 7;

   // Block interrupt status bits
   localparam int BIT_ST_EVENT    = 0;
   localparam int BIT_ST_CAPTURE  = 1;

   localparam logic [7:0] RST_CMP_CTRL = 8'h00;
   localparam logic [7:0] RST_BYTE     = 8'h00;

   typedef enum logic [1:0] {
      MODE_TOGGLE   = 2'b00,
      MODE_RESERVED = 2'b01,
      MODE_FALLING  = 2'b10,
      MODE_RISING   = 2'b11
   } irq_mode_t;

endpackage

//--- bench/cmp_ctrl_chk.sv
/* Port checker for analog_comparator_control.
   Bound from the bench top; sees only the block's ports. */
module cmp_ctrl_chk
   import cmp_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       cmp_raw,
   input wire logic       vector_ack,
   input wire logic       pos_pin_digital,
   input wire logic       pos_port_bit,
   input wire logic       cmp_power_off,
   input wire logic       neg_use_channel,
   input wire logic       capture_input,
   input wire logic       cmp_irq_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       acc;
   logic       wr_ctl;
   logic       wr_mux;
   logic       raw_q;
   logic [2:0] still_n;
   assign acc = psel && penable && pwrite && !pready;
   assign wr_ctl = acc && paddr == OFF_CMP_CTRL;
   assign wr_mux = acc && (paddr == OFF_CONV_CTRL_B || paddr == OFF_CONV_CTRL_A);
   // Cycles since the raw decision last moved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_q   <= 1'b0;
         still_n <= 3'd0;
      end else begin
         raw_q   <= cmp_raw;
         still_n <= (cmp_raw != raw_q) ? 3'd0 : still_n + {2'b00, still_n != 3'd7};
      end
   end
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("no answer after wait state");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_bad; psel && penable && !pready && paddr > 8'h1C |=> pslverr && pready; endproperty
   a_bad: assert property (p_bad) else $error("unmapped address not refused");
   property p_power; $changed(cmp_power_off) |-> $past(wr_ctl) || $past(wr_ctl, 2); endproperty
   a_power: assert property (p_power) else $error("power control moved without write");
   property p_neg; $changed(neg_use_channel) |-> $past(wr_mux) || $past(wr_mux, 2); endproperty
   a_neg: assert property (p_neg) else $error("negative source moved without write");
   property p_port; pos_port_bit |-> $past(pos_pin_digital); endproperty
   a_port: assert property (p_port) else $error("port bit high without pin");
   property p_vec; vector_ack && still_n > 3'd3 |-> ##2 !cmp_irq_req; endproperty
   a_vec: assert property (p_vec) else $error("vector did not clear request");
   property p_sync; $rose(capture_input) |-> $past(cmp_raw, 2) || $past(cmp_raw, 3); endproperty
   a_sync: assert property (p_sync) else $error("capture not from synced result");
   c_req: cover property ($rose(cmp_irq_req));
   c_cap: cover property ($rose(capture_input));
   c_err: cover property (pslverr);
endmodule

//--- bench/cmp_core_model.sv
/* Behavioural analog comparator core with its input switches.
   Millivolt levels come from the bench; the output sits low when off. */
module cmp_core_model (
   input  wire logic       power_off,
   input  wire logic       use_bandgap,
   input  wire logic       use_channel,
   input  wire logic [2:0] channel,
   input  var  int         pos_mv,
   input  var  int         neg_mv,
   input  var  int         bandgap_mv,
   input  var  int         chan_mv [8],
   output logic            cmp_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   int sel_pos;
   int sel_neg;
   always_comb begin
      sel_pos = use_bandgap ? bandgap_mv : pos_mv;
      sel_neg = use_channel ? chan_mv[channel] : neg_mv;
      cmp_raw = !power_off && sel_pos > sel_neg;
   end
endmodule

//--- bench/test_analog_comparator_control.sv
/* Bench for analog_comparator_control: APB master, core model, queued reads.
   Assumes cmp_pkg, the checker and the core model are compiled first. */
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
$display("ERROR %0t: got %h want %h", $time, a, e); end end
module test_analog_comparator_control
   import cmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, vector_ack, pos_pin_digital, neg_pin_digital;
   logic        pready, pslverr, cmp_raw, cmp_power_off, pos_use_bandgap, neg_use_channel, capture_input;
   logic        pos_port_bit, neg_port_bit, cmp_irq_req, irq;
   logic [2:0]  neg_channel_select;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rng;
   logic [32:0] exp_q [$];
   logic [32:0] exp_now;
   int          pos_mv, neg_mv, bg_mv, n_errors, check_count;
   int          chan_mv [8];
   analog_comparator_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .cmp_raw, .vector_ack, .pos_pin_digital, .neg_pin_digital, .cmp_power_off, .pos_use_bandgap,
      .neg_use_channel, .neg_channel_select, .capture_input, .pos_port_bit, .neg_port_bit, .cmp_irq_req, .irq);
   cmp_core_model model (.power_off(cmp_power_off), .use_bandgap(pos_use_bandgap), .use_channel(neg_use_channel),
      .channel(neg_channel_select), .pos_mv, .neg_mv, .bandgap_mv(bg_mv), .chan_mv, .cmp_raw);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin
         n_errors++;
         wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(a, 1'b0, 32'h0000_0000);
   endtask
   // Read answers are compared against the oldest queued expectation
   always @(posedge pclk) begin
      if (pready === 1'b1 && pwrite === 1'b0) begin
         if (exp_q.size() > 0) begin
            exp_now = exp_q.pop_front();
            `CHK({pslverr, prdata}, exp_now)
         end else begin
            n_errors++;
            $display("ERROR %0t: read answer with nothing expected", $time);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      wrap_up();
   end
   initial begin
      {psel, penable, pwrite, vector_ack, pos_pin_digital, neg_pin_digital, presetn} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pos_mv = 100;
      neg_mv = 500;
      bg_mv = 900;
      n_errors = 0;
      check_count = 0;
      chan_mv = '{default: 700};
      chan_mv[5] = 50;
      rng = 32'hac06_d5e5;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 36; a += 4) rd(a[7:0], {a == 32, 32'h0000_0000});
      $display("reset values done");
      wr(OFF_CONV_CTRL_B, 32'hffff_ffff);
      rd(OFF_CONV_CTRL_B, 33'h0_0000_0047);
      wr(OFF_CMP_CTRL, 32'h0000_0040);
      repeat (5) @(posedge pclk);
      rd(OFF_CMP_CTRL, 33'h0_0000_0070);
      wr(OFF_CMP_CTRL, 32'h0000_0090); // Interrupt enable stays off across the power change
      repeat (5) @(posedge pclk);
      rd(OFF_CMP_CTRL, 33'h0_0000_0090);
      wr(OFF_CMP_CTRL, 32'h0000_0010);
      wr(OFF_CONV_CHANNEL, 32'h0000_0005);
      repeat (5) @(posedge pclk);
      `CHK({neg_use_channel, neg_channel_select}, 4'hd)
      rd(OFF_CMP_CTRL, 33'h0_0000_0030);
      wr(OFF_CONV_CTRL_A, 32'h0000_0080);
      repeat (2) @(posedge pclk);
      `CHK(neg_use_channel, 1'b0)
      $display("selection done");
      wr(OFF_GLOBAL_IRQ, 32'h0000_0001);
      for (int m = 0; m < 4; m++) begin
         wr(OFF_CMP_CTRL, m | 32'h10); // Mode changes only with the interrupt disabled
         wr(OFF_CMP_CTRL, m | 32'h08);
         pos_mv <= 600;
         repeat (5) @(posedge pclk);
         `CHK(cmp_irq_req, m == 0 || m == 3)
         vector_ack <= 1'b1;
         @(posedge pclk);
         vector_ack <= 1'b0;
         repeat (3) @(posedge pclk);
         `CHK(cmp_irq_req, 1'b0)
         pos_mv <= 100;
         repeat (5) @(posedge pclk);
         rd(OFF_CMP_CTRL, {28'h000_0000, m == 0 || m == 2, 2'b10, m[1:0]});
         wr(OFF_CMP_CTRL, 32'h0000_0010);
      end
      $display("event modes done");
      `CHK(irq, 1'b0) // Status set but masked
      wr(OFF_IRQ_MASK, 32'h0000_0001);
      @(posedge pclk);
      `CHK(irq, 1'b1)
      wr(OFF_IRQ_STATUS, 32'h0000_0001);
      @(posedge pclk);
      `CHK(irq, 1'b0)
      wr(OFF_CMP_CTRL, 32'h0000_0004); // Timer-side capture enable lies beyond this block
      pos_mv <= 600;
      repeat (5) @(posedge pclk);
      `CHK(capture_input, 1'b1)
      wr(OFF_CMP_CTRL, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      `CHK(capture_input, 1'b0)
      rd(OFF_IRQ_STATUS, 33'h0_0000_0003);
      $display("interrupt and capture done");
      for (int i = 0; i < 6; i++) begin
         rng = xs(rng);
         pos_pin_digital <= rng[0];
         neg_pin_digital <= rng[1];
         wr(OFF_PIN_DISABLE, {30'h0000_0000, rng[3:2]});
         repeat (2) @(posedge pclk);
         `CHK({neg_port_bit, pos_port_bit}, rng[1:0] & ~rng[3:2])
         rd(OFF_PIN_DISABLE, {31'h0000_0000, rng[3:2]});
      end
      $display("pin disable done");
      repeat (2) @(posedge pclk);
      if (exp_q.size() != 0) n_errors++;
      wrap_up();
   end
endmodule
bind analog_comparator_control cmp_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
   .pslverr, .cmp_raw, .vector_ack, .pos_pin_digital, .pos_port_bit, .cmp_power_off, .neg_use_channel,
   .capture_input, .cmp_irq_req);
